// >>> core/core_memory_space_decode.sv
`timescale 1ns/1ns
module core_memory_space_decode #(
   parameter int STACK_LEVELS = mem_map_pkg::STACK_DEPTH
) (
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic RESET_N_I,
   input wire logic NMI_N_I,
   input wire logic PROG_ENTRY_I,
   input wire logic READOUT_PROTECT_I,
   input wire logic [11:0] FETCH_ADDR_I,
   input wire logic EXT_READ_I,
   input wire logic [7:0] PROG_DATA_I,
   input wire logic CALL_I,
   input wire logic RET_I,
   input wire logic [11:0] PUSH_ADDR_I,
   input wire logic NMI_ACK_I,
   input wire mem_map_pkg::data_req_s DATA_REQ_I,
   output logic [11:0] RET_ADDR_O,
   output logic STACK_OVF_O,
   output logic [2:0] STACK_LEVEL_O,
   output logic [2:0] PROG_REGION_O,
   output logic [11:0] PROG_ADDR_O,
   output logic [7:0] EXT_DATA_O,
   output logic EXT_REFUSED_O,
   output logic [3:0] DATA_REGION_O,
   output logic WIN_READ_O,
   output logic [7:0] WIN_BASE_O,
   output logic [7:0] BANK_SEL_O,
   output logic NMI_PENDING_O,
   output logic CORE_RESET_O,
   output logic [11:0] START_VEC_O,
   output logic PROG_MODE_O
);
   initial begin
      if (STACK_LEVELS < 1 || STACK_LEVELS > 7) begin
         $error("STACK_LEVELS must be 1..7");
      end
   end

   typedef struct packed {
      logic [2:0] rst_sync;
      logic [2:0] nmi_sync;
      logic [1:0] prog_sync;
      logic [2:0] sp;
      logic [6:0][11:0] stack;
      logic [11:0] ret_addr;
      logic ovf;
      logic [2:0] prog_region;
      logic [11:0] prog_addr;
      logic [7:0] ext_data;
      logic ext_refused;
      logic [3:0] data_region;
      logic win_rd;
      logic [7:0] win_base;
      logic [7:0] bank_sel;
      logic nmi_pend;
      logic core_rst;
      logic [11:0] start_vec;
      logic prog_mode;
   } state_s;

   state_s s_q, s_d;
   mem_map_pkg::data_route_s route;
   mem_map_pkg::prog_region_e preg;

   data_decode u_dec (
      .addr_i(DATA_REQ_I.addr),
      .win_base_i(s_q.win_base[mem_map_pkg::WIN_BASE_W-1:0]),
      .bank_sel_i(s_q.bank_sel),
      .route_o(route)
   );

   always_comb begin
      preg = mem_map_pkg::PR_RESERVED;
      if (FETCH_ADDR_I >= mem_map_pkg::USER_FIRST && FETCH_ADDR_I <= mem_map_pkg::USER_LAST) begin
         preg = mem_map_pkg::PR_USER;
      end else if (FETCH_ADDR_I >= mem_map_pkg::IRQ_VEC_FIRST
                   && FETCH_ADDR_I <= mem_map_pkg::IRQ_VEC_LAST) begin
         preg = mem_map_pkg::PR_IRQ_VEC;
      end else if (FETCH_ADDR_I[11:1] == mem_map_pkg::NMI_VEC_LO[11:1]) begin
         preg = mem_map_pkg::PR_NMI_VEC;
      end else if (FETCH_ADDR_I[11:1] == mem_map_pkg::RESET_VEC_LO[11:1]) begin
         preg = mem_map_pkg::PR_RESET_VEC;
      end
   end

   always_comb begin
      s_d = s_q;
      // synchronisers; stage 0 read only by stage 1
      s_d.rst_sync = {s_q.rst_sync[1:0], RESET_N_I};
      s_d.nmi_sync = {s_q.nmi_sync[1:0], NMI_N_I};
      s_d.prog_sync = {s_q.prog_sync[0], PROG_ENTRY_I};
      s_d.core_rst = !s_q.rst_sync[1];
      s_d.start_vec = mem_map_pkg::RESET_VEC_LO;
      if (!s_q.rst_sync[1]) begin
         s_d.prog_mode = s_q.prog_sync[1];
         s_d.sp = mem_map_pkg::SP_ZERO;
         s_d.ovf = 1'b0;
         s_d.nmi_pend = 1'b0;
      end else begin
         // falling edge wins over the acknowledge
         if (s_q.nmi_sync[2] && !s_q.nmi_sync[1]) begin
            s_d.nmi_pend = 1'b1;
         end else if (NMI_ACK_I) begin
            s_d.nmi_pend = 1'b0;
         end
         if (CALL_I) begin
            if (s_q.sp < 3'(STACK_LEVELS)) begin
               s_d.stack[s_q.sp] = PUSH_ADDR_I;
               s_d.sp = s_q.sp + 3'h1;
            end else begin
               s_d.ovf = 1'b1; // push address dropped on overflow; stack and sp kept
            end
         end else if (RET_I && s_q.sp != mem_map_pkg::SP_ZERO) begin
            s_d.ret_addr = s_q.stack[s_q.sp - 3'h1];
            s_d.sp = s_q.sp - 3'h1;
         end
      end
      s_d.prog_region = 3'(preg);
      s_d.prog_addr = FETCH_ADDR_I;
      if (EXT_READ_I) begin
         s_d.ext_refused = READOUT_PROTECT_I;
         s_d.ext_data = READOUT_PROTECT_I ? mem_map_pkg::FILL_BYTE : PROG_DATA_I;
      end
      s_d.data_region = 4'(route.region);
      s_d.win_rd = DATA_REQ_I.rd && route.win_rd;
      if (s_d.win_rd) begin
         s_d.prog_addr = route.prog_addr;
      end
      if (DATA_REQ_I.wr && DATA_REQ_I.addr == mem_map_pkg::WIN_BASE_ADDR) begin
         s_d.win_base = {2'b00, DATA_REQ_I.wdata[mem_map_pkg::WIN_BASE_W-1:0]};
      end
      if (DATA_REQ_I.wr && DATA_REQ_I.addr == mem_map_pkg::BANK_SEL_ADDR) begin
         s_d.bank_sel = DATA_REQ_I.wdata;
      end
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         s_q <= '0;
         s_q.rst_sync <= 3'h0;
         s_q.nmi_sync <= 3'h7;
         s_q.core_rst <= 1'b1;
         s_q.start_vec <= mem_map_pkg::RESET_VEC_LO;
      end else begin
         s_q <= s_d;
      end
   end

   assign RET_ADDR_O = s_q.ret_addr;
   assign STACK_OVF_O = s_q.ovf;
   assign STACK_LEVEL_O = s_q.sp;
   assign PROG_REGION_O = s_q.prog_region;
   assign PROG_ADDR_O = s_q.prog_addr;
   assign EXT_DATA_O = s_q.ext_data;
   assign EXT_REFUSED_O = s_q.ext_refused;
   assign DATA_REGION_O = s_q.data_region;
   assign WIN_READ_O = s_q.win_rd;
   assign WIN_BASE_O = s_q.win_base;
   assign BANK_SEL_O = s_q.bank_sel;
   assign NMI_PENDING_O = s_q.nmi_pend;
   assign CORE_RESET_O = s_q.core_rst;
   assign START_VEC_O = s_q.start_vec;
   assign PROG_MODE_O = s_q.prog_mode;
endmodule

// >>> core/mem_map_pkg.sv
package mem_map_pkg;
   localparam int PC_W = 12;
   localparam int DA_W = 8;
   localparam int DATA_W = 8;
   localparam int STACK_DEPTH = 6;
   localparam int WIN_LOW_W = 6;
   localparam int WIN_BASE_W = 6;
   localparam int BANK_W = 8;
   localparam logic [11:0] RESET_VEC_LO = 12'hFFE;
   localparam logic [11:0] NMI_VEC_LO = 12'hFFC;
   localparam logic [11:0] IRQ_VEC_FIRST = 12'hFF0;
   localparam logic [11:0] IRQ_VEC_LAST = 12'hFF7;
   localparam logic [11:0] RSV_VEC_FIRST = 12'hFF8;
   localparam logic [11:0] RSV_VEC_LAST = 12'hFFB;
   localparam logic [11:0] USER_FIRST = 12'h080;
   localparam logic [11:0] USER_LAST = 12'hF9F;
   localparam logic [11:0] RSV_HI_FIRST = 12'hFA0;
   localparam logic [11:0] RSV_HI_LAST = 12'hFEF;
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   localparam logic [7:0] BANK_FIRST = 8'h00;
   localparam logic [7:0] BANK_LAST = 8'h3F;
   localparam logic [7:0] WIN_FIRST = 8'h40;
   localparam logic [7:0] WIN_LAST = 8'h7F;
   localparam logic [7:0] RAM_FIRST = 8'h84;
   localparam logic [7:0] RAM_LAST = 8'hBF;
   localparam logic [7:0] WIN_BASE_ADDR = 8'hC9;
   localparam logic [7:0] BANK_SEL_ADDR = 8'hE8;
   localparam int BANK_RAM2_BIT = 4;
   localparam int BANK_EE1_BIT = 1;
   localparam int BANK_EE0_BIT = 0;
   localparam logic [11:0] PC_ZERO = 12'h000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [2:0] SP_ZERO = 3'h0;

   typedef enum logic [2:0] {
      PR_RESERVED, PR_USER, PR_IRQ_VEC, PR_NMI_VEC, PR_RESET_VEC
   } prog_region_e;

   typedef enum logic [3:0] {
      DR_NONE, DR_BANK_RAM2, DR_BANK_EE0, DR_BANK_EE1, DR_BANK_BASE,
      DR_WINDOW, DR_RAM, DR_REG
   } data_region_e;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } data_req_s;

   typedef struct packed {
      data_region_e region;
      logic [11:0] prog_addr;
      logic win_rd;
   } data_route_s;
endpackage

// >>> core/data_decode.sv
`timescale 1ns/1ns
module data_decode (
   input wire logic [7:0] addr_i,
   input wire logic [5:0] win_base_i,
   input wire logic [7:0] bank_sel_i,
   output mem_map_pkg::data_route_s route_o
);
   always_comb begin
      route_o.region = mem_map_pkg::DR_REG;
      route_o.prog_addr = {win_base_i, addr_i[mem_map_pkg::WIN_LOW_W-1:0]};
      route_o.win_rd = 1'b0;
      if (addr_i <= mem_map_pkg::BANK_LAST) begin
         // page 2 bit wins, then bit 1, if software sets several
         if (bank_sel_i[mem_map_pkg::BANK_RAM2_BIT]) begin
            route_o.region = mem_map_pkg::DR_BANK_RAM2;
         end else if (bank_sel_i[mem_map_pkg::BANK_EE1_BIT]) begin
            route_o.region = mem_map_pkg::DR_BANK_EE1;
         end else if (bank_sel_i[mem_map_pkg::BANK_EE0_BIT]) begin
            route_o.region = mem_map_pkg::DR_BANK_EE0;
         end else begin
            route_o.region = mem_map_pkg::DR_BANK_BASE;
         end
      end else if (addr_i >= mem_map_pkg::WIN_FIRST && addr_i <= mem_map_pkg::WIN_LAST) begin
         route_o.region = mem_map_pkg::DR_WINDOW;
         route_o.win_rd = 1'b1;
      end else if (addr_i >= mem_map_pkg::RAM_FIRST && addr_i <= mem_map_pkg::RAM_LAST) begin
         route_o.region = mem_map_pkg::DR_RAM;
      end
   end
endmodule

// >>> verif/mem_map_chk.sv
`timescale 1ns/1ns
module mem_map_chk #(
   parameter int STACK_LEVELS = 6
) (
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic NMI_N_I,
   input wire logic READOUT_PROTECT_I,
   input wire logic [11:0] FETCH_ADDR_I,
   input wire logic EXT_READ_I,
   input wire logic CALL_I,
   input wire mem_map_pkg::data_req_s DATA_REQ_I,
   input wire logic STACK_OVF_O,
   input wire logic [2:0] STACK_LEVEL_O,
   input wire logic [2:0] PROG_REGION_O,
   input wire logic [11:0] PROG_ADDR_O,
   input wire logic [7:0] EXT_DATA_O,
   input wire logic EXT_REFUSED_O,
   input wire logic [3:0] DATA_REGION_O,
   input wire logic WIN_READ_O,
   input wire logic [7:0] WIN_BASE_O,
   input wire logic [7:0] BANK_SEL_O,
   input wire logic NMI_PENDING_O,
   input wire logic [11:0] START_VEC_O
);
   logic [11:0] win_exp_q;
   logic fetch_ok;
   assign fetch_ok = !DATA_REQ_I.rd;
   always_ff @(posedge CLK_I) win_exp_q <= {WIN_BASE_O[5:0], DATA_REQ_I.addr[5:0]};
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   AST_WIN_ADDR: assert property (DATA_REQ_I.rd && DATA_REQ_I.addr[7:6] == 2'h1
      |=> WIN_READ_O && PROG_ADDR_O == win_exp_q) else $error("window address mismatch");
   AST_START_VEC: assert property (START_VEC_O == 12'hFFE) else $error("bad start vector");
   AST_LOW_RSV: assert property (fetch_ok && FETCH_ADDR_I < 12'h080
      |=> PROG_REGION_O == 3'h0) else $error("low area not reserved");
   AST_NMI_VEC: assert property (fetch_ok && FETCH_ADDR_I[11:1] == 11'h7FE
      |=> PROG_REGION_O == 3'h3) else $error("nmi vector not decoded");
   AST_IRQ_VEC: assert property (fetch_ok && FETCH_ADDR_I[11:3] == 9'h1FE
      |=> PROG_REGION_O == 3'h2) else $error("irq vector not decoded");
   AST_REFUSE: assert property (EXT_READ_I && READOUT_PROTECT_I
      |=> EXT_REFUSED_O && EXT_DATA_O == 8'hFF) else $error("protected read leaked");
   AST_BANK_RAM2: assert property ((DATA_REQ_I.rd || DATA_REQ_I.wr) &&
      DATA_REQ_I.addr <= 8'h3F && BANK_SEL_O[4] |=> DATA_REGION_O == 4'h1)
      else $error("bank page 2 not routed");
   AST_NMI_EDGE: assert property ($fell(NMI_N_I) |-> ##[1:4] NMI_PENDING_O)
      else $error("nmi edge missed");
   AST_STACK_OVF: assert property (CALL_I && STACK_LEVEL_O == STACK_LEVELS |=> STACK_OVF_O)
      else $error("stack overflow not flagged");
   cover property (WIN_READ_O);
   cover property ($rose(STACK_OVF_O));
   cover property ($rose(NMI_PENDING_O));
endmodule
bind core_memory_space_decode mem_map_chk #(.STACK_LEVELS(STACK_LEVELS)) mem_map_chk_inst (
   .CLK_I, .RESET_I, .NMI_N_I, .READOUT_PROTECT_I, .FETCH_ADDR_I, .EXT_READ_I, .CALL_I,
   .DATA_REQ_I, .STACK_OVF_O, .STACK_LEVEL_O, .PROG_REGION_O, .PROG_ADDR_O, .EXT_DATA_O,
   .EXT_REFUSED_O, .DATA_REGION_O, .WIN_READ_O, .WIN_BASE_O, .BANK_SEL_O, .NMI_PENDING_O,
   .START_VEC_O);

// >>> verif/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic CLK_I = 1'h0, RESET_I = 1'h1, RESET_N_I = 1'h0, NMI_N_I = 1'h1, PROG_ENTRY_I = 1'h0;
   logic READOUT_PROTECT_I = 1'h0, EXT_READ_I = 1'h0, CALL_I = 1'h0, RET_I = 1'h0, NMI_ACK_I = 1'h0;
   logic [11:0] FETCH_ADDR_I = '0, PUSH_ADDR_I = '0, RET_ADDR_O, PROG_ADDR_O, START_VEC_O, e;
   logic [7:0] PROG_DATA_I = '0, EXT_DATA_O, WIN_BASE_O, BANK_SEL_O;
   logic STACK_OVF_O, EXT_REFUSED_O, WIN_READ_O, NMI_PENDING_O, CORE_RESET_O, PROG_MODE_O;
   logic [2:0] STACK_LEVEL_O, PROG_REGION_O;
   logic [3:0] DATA_REGION_O;
   logic [5:0] base = '0;
   logic [7:0] bv[4] = '{8'h10, 8'h02, 8'h01, 8'h00};
   logic [3:0] br[4] = '{4'h1, 4'h3, 4'h2, 4'h4};
   mem_map_pkg::data_req_s DATA_REQ_I = '0;
   logic [11:0] exp_q[$];
   int errors = 0, checks_done = 0;
   core_memory_space_decode core_memory_space_decode_inst (.CLK_I, .RESET_I, .RESET_N_I,
      .NMI_N_I, .PROG_ENTRY_I, .READOUT_PROTECT_I, .FETCH_ADDR_I, .EXT_READ_I, .PROG_DATA_I,
      .CALL_I, .RET_I, .PUSH_ADDR_I, .NMI_ACK_I, .DATA_REQ_I, .RET_ADDR_O, .STACK_OVF_O,
      .STACK_LEVEL_O, .PROG_REGION_O, .PROG_ADDR_O, .EXT_DATA_O, .EXT_REFUSED_O,
      .DATA_REGION_O, .WIN_READ_O, .WIN_BASE_O, .BANK_SEL_O, .NMI_PENDING_O,
      .CORE_RESET_O, .START_VEC_O, .PROG_MODE_O);
   always #5 CLK_I = ~CLK_I;
   task automatic chk(input logic [11:0] g, x);
      checks_done++;
      if (g !== x) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge CLK_I);
   endtask
   task automatic conclude;
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // one data access; window reads queue their program address
   task automatic dreq(input logic r, w, input logic [7:0] a, d);
      DATA_REQ_I = '{rd: r, wr: w, addr: a, wdata: d};
      if (w && a == 8'hC9) base = d[5:0];
      if (r && a[7:6] == 2'h1) exp_q.push_back({base, a[5:0]});
      cyc(1);
   endtask
   function automatic logic [2:0] region_of(input logic [11:0] a);
      if (a >= 12'hFFE) return 3'h4;
      if (a >= 12'hFFC) return 3'h3;
      if (a >= 12'hFF8) return 3'h0;
      if (a >= 12'hFF0) return 3'h2;
      return (a >= 12'h080 && a <= 12'hF9F) ? 3'h1 : 3'h0;
   endfunction
   always @(negedge CLK_I) begin
      if (WIN_READ_O === 1'h1) begin
         e = 'x;
         if (exp_q.size() > 0) e = exp_q.pop_front();
         chk(PROG_ADDR_O, e);
      end
   end
   initial begin
      #100000;
      errors++;
      conclude;
   end
   initial begin
      void'($urandom(32'hEB9FB24E));
      cyc(6);
      chk(START_VEC_O, 12'hFFE);
      RESET_I = 1'h0;
      RESET_N_I = 1'h1;
      cyc(5);
      chk(CORE_RESET_O, 12'h000);
      chk(PROG_MODE_O, 12'h000);
      RESET_N_I = 1'h0;
      PROG_ENTRY_I = 1'h1;
      cyc(5);
      chk(CORE_RESET_O, 12'h001);
      RESET_N_I = 1'h1;
      PROG_ENTRY_I = 1'h0;
      cyc(5);
      chk(PROG_MODE_O, 12'h001);
      for (int i = 0; i < 160; i++) begin
         FETCH_ADDR_I = i < 128 ? 12'hF80 + 12'(i) :
            i < 136 ? 12'h07C + 12'(i - 128) : 12'($urandom);
         cyc(1);
         chk(PROG_REGION_O, region_of(FETCH_ADDR_I));
      end
      dreq(1'h0, 1'h1, 8'hC9, 8'h28);
      chk(WIN_BASE_O, 12'h028);
      dreq(1'h1, 1'h0, 8'h59, 8'h00);
      repeat (20) begin
         dreq(1'h0, 1'h1, 8'hC9, 8'($urandom));
         dreq(1'h1, 1'h0, 8'h40 + 8'($urandom % 64), 8'h00);
         chk(DATA_REGION_O, 4'h5);
      end
      for (int i = 0; i < 4; i++) begin
         dreq(1'h0, 1'h1, 8'hE8, bv[i]);
         chk(BANK_SEL_O, bv[i]);
         dreq(1'h1, 1'h0, 8'($urandom % 64), 8'h00);
         chk(DATA_REGION_O, br[i]);
         dreq(1'h1, 1'h0, 8'h84 + 8'($urandom % 60), 8'h00);
         chk(DATA_REGION_O, 4'h6);
      end
      DATA_REQ_I = '0;
      PROG_DATA_I = 8'($urandom);
      EXT_READ_I = 1'h1;
      for (int i = 0; i < 2; i++) begin
         READOUT_PROTECT_I = 1'(i);
         cyc(1);
         chk(EXT_DATA_O, i ? 8'hFF : PROG_DATA_I);
         chk(EXT_REFUSED_O, 12'(i));
      end
      // image byte of a reserved location as the loader must leave it
      READOUT_PROTECT_I = 1'h0;
      FETCH_ADDR_I = 12'hFF9;
      PROG_DATA_I = 8'hFF;
      cyc(1);
      EXT_READ_I = 1'h0;
      chk(EXT_DATA_O, 12'h0FF);
      chk(PROG_REGION_O, 12'h000);
      CALL_I = 1'h1;
      repeat (6) begin
         PUSH_ADDR_I = 12'($urandom);
         cyc(1);
      end
      CALL_I = 1'h0;
      RET_I = 1'h1;
      chk(STACK_LEVEL_O, 12'h006);
      chk(STACK_OVF_O, 12'h000);
      cyc(1);
      RET_I = 1'h0;
      chk(RET_ADDR_O, PUSH_ADDR_I);
      CALL_I = 1'h1;
      cyc(2);
      CALL_I = 1'h0;
      chk(STACK_OVF_O, 12'h001);
      NMI_N_I = 1'h0;
      cyc(5);
      chk(NMI_PENDING_O, 12'h001);
      NMI_N_I = 1'h1;
      NMI_ACK_I = 1'h1;
      cyc(1);
      NMI_ACK_I = 1'h0;
      cyc(1);
      chk(NMI_PENDING_O, 12'h000);
      chk(12'(exp_q.size()), 12'h000);
      conclude;
   end
endmodule
